/* File: core/scan_phase.v */
// tracks scan boundaries and the first scan after a flag event or run entry
`timescale 1ns/100ps
module scan_phase (
    input wire clk,
    input wire rst,
    input wire scan_start,
    input wire arm,
    output reg active
);
    // armed event waits for a scan start, then covers that scan, ends at next start
    reg pend_r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
            active <= 1'b0;
        end else begin
            if (scan_start) begin
                active <= pend_r | arm;
                pend_r <= 1'b0;
            end else if (arm) begin
                pend_r <= 1'b1;
            end
        end
    end
endmodule // scan_phase

/* File: core/sysbits_consts.vh */
// constants for the controller system status and control flag bank
//
// Behaviour
// RULE_01 - cold-start flag raised by lost-data power return, cartridge change, reset button, request
// RULE_02 - cold-start flag reads 1 through first full scan, cleared before next scan
// RULE_03 - warm-restart flag raised by retained-data power return or software request
// RULE_04 - warm-restart flag cleared at end of first scan, before output update
// RULE_05 - four time-base bits toggle at 10 ms, 100 ms, 1 s, 1 min, scan-independent
// RULE_06 - wiring-test bit resets to 1; unconfigured with bit 1 forces outputs to 0
// RULE_07 - unconfigured with wiring-test bit 0 lets adjustment terminal drive outputs
// RULE_08 - output-fallback bit at 1 forces all outputs to fallback values
// RULE_09 - output-fallback bit at 0 lets program results update outputs
// RULE_10 - I/O-healthy bit resets to 1, drops to 0 on any detected I/O fault
// RULE_11 - I/O-healthy bit returns to 1 by itself when the fault goes away
// RULE_12 - watchdog-overrun flag set when a task exceeds maximum execution time
// RULE_13 - watchdog overrun stops controller in error mode with error lamp flashing
// RULE_14 - first-scan flag is 1 during first scan after entering run, else 0
// RULE_15 - string-overflow flag set when string destination area is too small
// RULE_16 - software must clear the string-overflow flag itself
// RULE_17 - software must not write back bits the device returns to normal
// RULE_18 - watchdog, first-scan, I/O-healthy bits device-only; string flag cleared by software
// RULE_19 - first-scan flag cleared automatically at start of second scan after run entry
`ifndef SYSBITS_CONSTS_VH
`define SYSBITS_CONSTS_VH

// word offsets (byte addresses)
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_REQ 4'h8
`define OFS_FALLBACK 4'hC

// control and request register fields
`define BIT_WIRING 0
`define BIT_FALLBACK 1
`define BIT_COLD 0
`define BIT_WARM 1
`define BIT_STRING 2

// status register fields
`define ST_COLD 0
`define ST_WARM 1
`define ST_TB10MS 4
`define ST_TB100MS 5
`define ST_TB1S 6
`define ST_TB1MIN 7
`define ST_WIRING 8
`define ST_FALLBACK 9
`define ST_IOOK 10
`define ST_WDOG 11
`define ST_FIRST 13
`define ST_STRING 15
`define ST_STOPPED 16

`define RST_WIRING 1'b1
`define RST_FALLBACK 1'b0
`define RST_IOOK 1'b1

// time-base periods and clock rate
`define CLK_HZ 32'h05F5E100
`define TB10MS_MS 10
`define TB100MS_MS 100
`define TB1S_MS 1000
`define TB1MIN_MS 60000
// half period in cycles: bit toggles twice per period
// kept unsigned 32-bit: the minute half period overflows a signed integer
`define HALF_CYC(ms) ((ms) * (`CLK_HZ / 32'h000007D0))

`endif

/* File: core/sysbits_top.v */
// system status and control flag bank with scan-driven and free-running bits
`include "sysbits_consts.vh"
`timescale 1ns/100ps
module sysbits_top #(
    parameter integer NOUT = 16,
    parameter [31:0] HALF_10MS = `HALF_CYC(`TB10MS_MS),
    parameter [31:0] HALF_100MS = `HALF_CYC(`TB100MS_MS),
    parameter [31:0] HALF_1S = `HALF_CYC(`TB1S_MS),
    parameter [31:0] HALF_1MIN = `HALF_CYC(`TB1MIN_MS),
    parameter integer LAMP_HALF = `HALF_CYC(250)
) (
    input wire SYS_CLK,
    input wire RST,
    input wire [3:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    output reg [1:0] AVS_RESPONSE,
    input wire PWR_RETURN_LOST,
    input wire PWR_RETURN_KEPT,
    input wire CARTRIDGE_CHANGE,
    input wire RESET_BUTTON,
    input wire SCAN_START,
    input wire SCAN_END,
    input wire RUN_ENTRY,
    input wire CONFIGURED,
    input wire IO_FAULT,
    input wire TASK_OVERRUN,
    input wire STRING_TOO_SMALL,
    input wire RESTART_STOP,
    input wire [NOUT-1:0] PROGRAM_OUT,
    input wire [NOUT-1:0] ADJUST_OUT,
    output reg [NOUT-1:0] OUTPUTS,
    output wire STOPPED,
    output wire ERR_LAMP
);
    reg wiring_test_enable_r;
    reg output_fallback_force_r;
    reg [NOUT-1:0] fallback_val_r;
    reg cold_arm_r;
    reg warm_arm_r;
    reg warm_r;
    reg watchdog_overrun_flag_r;
    reg string_overflow_flag_r;
    reg stopped_r;
    reg ack_r;
    reg [31:0] lamp_cnt_r;
    reg lamp_r;
    reg [NOUT-1:0] out_nxt;
    reg [31:0] rd_nxt;
    wire cold_start_flag;
    wire first_scan_flag;
    wire io_healthy_flag;
    wire [3:0] time_base;
    wire sel_ctrl = (AVS_ADDRESS == `OFS_CTRL);
    wire sel_status = (AVS_ADDRESS == `OFS_STATUS);
    wire sel_req = (AVS_ADDRESS == `OFS_REQ);
    wire sel_fb = (AVS_ADDRESS == `OFS_FALLBACK);
    wire mapped = sel_ctrl | sel_status | sel_req | sel_fb;
    wire req = AVS_READ | AVS_WRITE;
    // one wait state: the request completes on the edge after it is seen
    wire wr = AVS_WRITE & ack_r & AVS_BYTEENABLE[0];
    wire wr_req = wr & sel_req;
    wire sw_cold = wr_req & AVS_WRITEDATA[`BIT_COLD];
    wire sw_warm = wr_req & AVS_WRITEDATA[`BIT_WARM];
    wire sw_str_clr = wr_req & AVS_WRITEDATA[`BIT_STRING];
    wire cold_evt = PWR_RETURN_LOST | CARTRIDGE_CHANGE | RESET_BUTTON | sw_cold; // RULE_01
    wire warm_evt = PWR_RETURN_KEPT | sw_warm; // RULE_03

    assign AVS_WAITREQUEST = req & ~ack_r;

    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // cold flag covers the whole first scan after the event, gone at next start
    scan_phase cold_phase (
        .clk(SYS_CLK),
        .rst(RST),
        .scan_start(SCAN_START),
        .arm(cold_arm_r),
        .active(cold_start_flag)
    ); // RULE_02

    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cold_arm_r <= 1'b0;
        end else begin
            cold_arm_r <= cold_evt;
        end
    end

    scan_phase first_phase (
        .clk(SYS_CLK),
        .rst(RST),
        .scan_start(SCAN_START),
        .arm(RUN_ENTRY),
        .active(first_scan_flag)
    ); // RULE_14 RULE_19

    // warm flag: raised at the next scan start, dropped at that scan's end
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            warm_arm_r <= 1'b0;
            warm_r <= 1'b0;
        end else begin
            if (SCAN_START) begin
                warm_r <= warm_arm_r | warm_evt;
                warm_arm_r <= 1'b0;
            end else begin
                if (warm_evt) begin
                    warm_arm_r <= 1'b1;
                end
                if (SCAN_END) begin
                    warm_r <= 1'b0; // RULE_04
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : tbase
            tb_divider #(
                .HALF(g == 0 ? HALF_10MS : g == 1 ? HALF_100MS : g == 2 ? HALF_1S : HALF_1MIN)
            ) div (
                .clk(SYS_CLK),
                .rst(RST),
                .tb(time_base[g])
            ); // RULE_05
        end
    endgenerate

    // follows the fault live, so it heals without any software clear
    assign io_healthy_flag = ~IO_FAULT; // RULE_10 RULE_11

    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wiring_test_enable_r <= `RST_WIRING; // RULE_06
            output_fallback_force_r <= `RST_FALLBACK;
            fallback_val_r <= {NOUT{1'b0}};
            watchdog_overrun_flag_r <= 1'b0;
            string_overflow_flag_r <= 1'b0;
            stopped_r <= 1'b0;
        end else begin
            if (wr & sel_ctrl) begin
                wiring_test_enable_r <= AVS_WRITEDATA[`BIT_WIRING];
                output_fallback_force_r <= AVS_WRITEDATA[`BIT_FALLBACK];
            end
            if (wr & sel_fb) begin
                fallback_val_r <= AVS_WRITEDATA[NOUT-1:0];
            end
            // device-only bits; software may only clear the string flag
            if (TASK_OVERRUN) begin
                watchdog_overrun_flag_r <= 1'b1; // RULE_12 RULE_18
            end else if (RESTART_STOP) begin
                watchdog_overrun_flag_r <= 1'b0;
            end
            if (STRING_TOO_SMALL) begin
                string_overflow_flag_r <= 1'b1; // RULE_15
            end else if (sw_str_clr) begin
                string_overflow_flag_r <= 1'b0; // RULE_18
            end
            if (TASK_OVERRUN) begin
                stopped_r <= 1'b1; // RULE_13
            end else if (RESTART_STOP) begin
                stopped_r <= 1'b0;
            end
        end
    end

    // error lamp flashes while stopped in error mode
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            lamp_cnt_r <= 32'h00000000;
            lamp_r <= 1'b0;
        end else if (!stopped_r) begin
            lamp_cnt_r <= 32'h00000000;
            lamp_r <= 1'b0;
        end else if (lamp_cnt_r == LAMP_HALF - 1) begin
            lamp_cnt_r <= 32'h00000000;
            lamp_r <= ~lamp_r; // RULE_13
        end else begin
            lamp_cnt_r <= lamp_cnt_r + 32'h00000001;
        end
    end
    assign STOPPED = stopped_r;
    assign ERR_LAMP = lamp_r;

    // output selection; fallback force outranks everything; a forced stop gives fallback values only when configured
    always @* begin
        out_nxt = OUTPUTS;
        if (output_fallback_force_r) begin
            out_nxt = fallback_val_r; // RULE_08
        end else if (!CONFIGURED) begin
            if (wiring_test_enable_r) begin
                out_nxt = {NOUT{1'b0}}; // RULE_06
            end else begin
                out_nxt = ADJUST_OUT; // RULE_07
            end
        end else if (stopped_r) begin
            out_nxt = fallback_val_r;
        end else if (SCAN_END) begin
            out_nxt = PROGRAM_OUT; // RULE_09
        end
    end

    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            OUTPUTS <= {NOUT{1'b0}};
        end else begin
            OUTPUTS <= out_nxt;
        end
    end

    always @* begin
        rd_nxt = 32'h00000000;
        if (sel_ctrl) begin
            rd_nxt[`BIT_WIRING] = wiring_test_enable_r;
            rd_nxt[`BIT_FALLBACK] = output_fallback_force_r;
        end else if (sel_status) begin
            rd_nxt[`ST_COLD] = cold_start_flag;
            rd_nxt[`ST_WARM] = warm_r;
            rd_nxt[`ST_TB1MIN:`ST_TB10MS] = time_base;
            rd_nxt[`ST_WIRING] = wiring_test_enable_r;
            rd_nxt[`ST_FALLBACK] = output_fallback_force_r;
            rd_nxt[`ST_IOOK] = io_healthy_flag;
            rd_nxt[`ST_WDOG] = watchdog_overrun_flag_r;
            rd_nxt[`ST_FIRST] = first_scan_flag;
            rd_nxt[`ST_STRING] = string_overflow_flag_r;
            rd_nxt[`ST_STOPPED] = stopped_r;
        end else if (sel_fb) begin
            rd_nxt[NOUT-1:0] = fallback_val_r;
        end
    end

    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            AVS_READDATA <= 32'h00000000;
            AVS_RESPONSE <= 2'h0;
        end else begin
            AVS_READDATA <= rd_nxt;
            // unmapped addresses answer with a slave error, reads as zero
            AVS_RESPONSE <= mapped ? 2'h0 : 2'h2;
        end
    end
endmodule // sysbits_top

/* File: core/tb_divider.v */
// free-running half-period divider driving one time-base bit
`timescale 1ns/100ps
module tb_divider #(
    parameter [31:0] HALF = 32'h0007A120
) (
    input wire clk,
    input wire rst,
    output reg tb
);
    reg [31:0] cnt_r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h00000000;
            tb <= 1'b0;
        end else if (cnt_r == HALF - 32'h00000001) begin
            cnt_r <= 32'h00000000;
            tb <= ~tb;
        end else begin
            cnt_r <= cnt_r + 32'h00000001;
        end
    end
endmodule // tb_divider

/* File: verif/controller_system_status_bits_test.sv */
// self-checking bench for the system flag bank
`timescale 1ns/100ps
module controller_system_status_bits_test;
    reg SYS_CLK = 0;
    reg RST = 1;
    reg [3:0] a = 0;
    reg rd_q = 0;
    reg wr_q = 0;
    reg [31:0] wd = 0;
    reg [9:0] ev = 0;
    reg cfg = 0;
    reg iof = 0;
    reg [15:0] prog = 0;
    reg [15:0] adj = 0;
    wire [31:0] rdata;
    wire wq;
    wire [1:0] resp;
    wire [15:0] outs;
    wire stp;
    wire lmp;
    reg lp;
    reg [3:0] be = 4'hF;
    reg [31:0] r;
    reg [31:0] x;
    reg [1:0] rs;
    reg [3:0] last;
    integer tgl [0:3];
    integer bad_count = 0;
    integer comparisons = 0;
    integer seed = 18;
    integer i, k, n, h;
    sysbits_top #(.HALF_10MS(4), .HALF_100MS(5), .HALF_1S(7), .HALF_1MIN(9), .LAMP_HALF(4)) uut (
        .SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(a), .AVS_READ(rd_q), .AVS_WRITE(wr_q),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wq), .AVS_RESPONSE(resp), .PWR_RETURN_LOST(ev[0]),
        .CARTRIDGE_CHANGE(ev[1]), .RESET_BUTTON(ev[2]), .PWR_RETURN_KEPT(ev[3]),
        .RUN_ENTRY(ev[4]), .SCAN_START(ev[5]), .SCAN_END(ev[6]), .TASK_OVERRUN(ev[7]),
        .STRING_TOO_SMALL(ev[8]), .RESTART_STOP(ev[9]), .CONFIGURED(cfg), .IO_FAULT(iof),
        .PROGRAM_OUT(prog), .ADJUST_OUT(adj), .OUTPUTS(outs), .STOPPED(stp), .ERR_LAMP(lmp));
    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task final_report;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // request stands until the rising edge where waitrequest is low; data taken there
    task av(input w, input [3:0] ad, input [31:0] d);
        begin
            @(posedge SYS_CLK);
            rd_q <= !w;
            wr_q <= w;
            a <= ad;
            wd <= d;
            n = 0;
            @(posedge SYS_CLK);
            while (wq !== 1'b0 && n < 20) begin
                @(posedge SYS_CLK);
                n = n + 1;
            end
            r = rdata;
            rs = resp;
            if (n == 20) cmp(32'h0, 32'h1);
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end
    endtask
    task st;
        av(1'b0, 4'h4, 32'h0);
    endtask
    task pulse(input integer b);
        begin
            @(posedge SYS_CLK);
            ev[b] <= 1'b1;
            @(posedge SYS_CLK);
            ev[b] <= 1'b0;
        end
    endtask
    function [15:0] exp_out(input c, input wt, input fb, input [15:0] p, input [15:0] ad,
                            input [15:0] fv);
        exp_out = fb ? fv : c ? p : wt ? 16'h0000 : ad;
    endfunction
    initial begin
        #50000;
        bad_count = bad_count + 1;
        final_report;
    end
    initial begin
        repeat (2) @(posedge SYS_CLK);
        RST <= 1'b0;
        st;
        cmp(r & 32'hFFFFFF0F, 32'h00000500);
        av(1'b0, 4'h2, 32'h0);
        cmp(r | rs, 32'h2);
        // events 0..4 on pins, then cold and warm requests through the request word
        for (i = 0; i < 7; i = i + 1) begin
            if (i < 5) pulse(i);
            else av(1'b1, 4'h8, i - 4);
            k = (i == 3 || i == 6) ? 1 : (i == 4) ? 13 : 0;
            pulse(5);
            st;
            cmp(r[k], 1);
            pulse(6);
            st;
            cmp(r[k], k != 1);
            pulse(5);
            st;
            cmp(r[k], 0);
        end
        pulse(7);
        // lamp half period is 4 cycles, so 12 cycles show two or three lamp toggles
        n = 0;
        lp = lmp;
        repeat (12) begin
            @(posedge SYS_CLK);
            if (lmp !== lp) n = n + 1;
            lp = lmp;
        end
        cmp(n >= 2 && n <= 3 && stp === 1'b1, 1);
        av(1'b1, 4'h4, 32'hFFFFFFFF);
        st;
        cmp(r & 32'h0001AC00, 32'h00010C00);
        pulse(9);
        st;
        cmp(r & 32'h00010800, 32'h0);
        cmp({30'h0, stp, lmp}, 32'h0);
        pulse(8);
        pulse(5);
        st;
        cmp(r[15], 1);
        av(1'b1, 4'h8, 32'h4);
        st;
        cmp(r[15], 0);
        iof <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        st;
        cmp(r[10], 0);
        iof <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        st;
        cmp(r[10], 1);
        // reads come every 3 cycles, faster than the shortest half period of 4
        last = r[7:4];
        for (k = 0; k < 4; k = k + 1) tgl[k] = 0;
        for (i = 0; i < 40; i = i + 1) begin
            st;
            for (k = 0; k < 4; k = k + 1) if (r[4 + k] != last[k]) tgl[k] = tgl[k] + 1;
            last = r[7:4];
        end
        for (k = 0; k < 4; k = k + 1) begin
            h = (k == 0) ? 4 : (k == 1) ? 5 : (k == 2) ? 7 : 9;
            cmp(tgl[k] >= 120 / h - 1 && tgl[k] <= 120 / h + 1, 1);
        end
        for (i = 0; i < 24; i = i + 1) begin
            x = $random(seed);
            // first four passes: wiring test, adjust, fallback, configured
            if (i < 4) x[2:0] = 12'o1402 >> (3 * i);
            cfg <= x[0];
            prog <= $random(seed);
            adj <= $random(seed);
            av(1'b1, 4'hC, {16'h0000, x[31:16]});
            av(1'b1, 4'h0, {30'h0, x[2:1]});
            pulse(6);
            @(negedge SYS_CLK);
            cmp(outs, exp_out(x[0], x[1], x[2], prog, adj, x[31:16]));
            st;
            cmp(r[9:8], x[2:1]);
        end
        // lane 0 disabled: the inverted control write must be ignored
        be <= 4'hE;
        av(1'b1, 4'h0, {30'h0, ~x[2:1]});
        be <= 4'hF;
        st;
        cmp(r[9:8], x[2:1]);
        final_report;
    end
endmodule // controller_system_status_bits_test

/* File: verif/sysbits_top_chk.sv */
// concurrent checks on the pins of the system flag bank
`timescale 1ns/100ps
module sysbits_top_chk #(
    parameter integer NOUT = 16
) (
    input wire SYS_CLK,
    input wire RST,
    input wire [3:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    input wire AVS_WAITREQUEST,
    input wire [1:0] AVS_RESPONSE,
    input wire SCAN_END,
    input wire CONFIGURED,
    input wire TASK_OVERRUN,
    input wire RESTART_STOP,
    input wire [NOUT-1:0] PROGRAM_OUT,
    input wire [NOUT-1:0] ADJUST_OUT,
    input wire [NOUT-1:0] OUTPUTS,
    input wire STOPPED,
    input wire ERR_LAMP
);
    reg wiring_r;
    reg fb_r;
    reg [NOUT-1:0] fv_r;
    wire wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    wire m_wt = !CONFIGURED && wiring_r && !fb_r && !STOPPED;
    wire m_adj = !CONFIGURED && !wiring_r && !fb_r && !STOPPED;
    wire m_prog = CONFIGURED && !fb_r && !STOPPED;
    // mirror of the control words so output modes can be judged from the pins
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wiring_r <= 1'b1;
            fb_r <= 1'b0;
            fv_r <= {NOUT{1'b0}};
        end else if (wr_ok && AVS_ADDRESS == 4'h0) begin
            wiring_r <= AVS_WRITEDATA[0];
            fb_r <= AVS_WRITEDATA[1];
        end else if (wr_ok && AVS_ADDRESS == 4'hC) begin
            fv_r <= AVS_WRITEDATA[NOUT-1:0];
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_one_wait;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    sequence s_blink;
        ##[1:8] $changed(ERR_LAMP);
    endsequence
    a_bus_one_wait: assert property ($rose(AVS_READ || AVS_WRITE) |-> s_one_wait)
        else $error("request not answered after exactly one wait cycle");
    a_unmapped_resp: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'b00
        |-> AVS_RESPONSE == 2'b10) else $error("unmapped read not flagged");
    a_wiring_zero: assert property (SCAN_END && m_wt |=> OUTPUTS == {NOUT{1'b0}})
        else $error("wiring test did not force outputs low");
    a_adjust_drive: assert property (SCAN_END && m_adj |=> OUTPUTS == $past(ADJUST_OUT))
        else $error("adjustment values not on outputs");
    a_fallback_force: assert property (SCAN_END && fb_r |=> OUTPUTS == $past(fv_r))
        else $error("fallback values not on outputs");
    a_program_update: assert property (SCAN_END && m_prog |=> OUTPUTS == $past(PROGRAM_OUT))
        else $error("program results not on outputs");
    a_overrun_stop: assert property (TASK_OVERRUN |-> ##[1:2] STOPPED)
        else $error("overrun did not stop the controller");
    a_stop_hold: assert property (STOPPED && !RESTART_STOP |=> STOPPED)
        else $error("stop left without restart");
    a_lamp_blink: assert property ($rose(STOPPED) |-> s_blink)
        else $error("error lamp not flashing");
endmodule // sysbits_top_chk
bind sysbits_top sysbits_top_chk #(.NOUT(NOUT)) chk (.SYS_CLK(SYS_CLK), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE), .SCAN_END(SCAN_END),
    .CONFIGURED(CONFIGURED), .TASK_OVERRUN(TASK_OVERRUN), .RESTART_STOP(RESTART_STOP),
    .PROGRAM_OUT(PROGRAM_OUT), .ADJUST_OUT(ADJUST_OUT), .OUTPUTS(OUTPUTS),
    .STOPPED(STOPPED), .ERR_LAMP(ERR_LAMP));
